/* hw/phy_event_cfg.svh */
`ifndef PHY_EVENT_CFG_SVH
`define PHY_EVENT_CFG_SVH

`define PHY_EVENT_REG_ADDR 5'h11
`define PHY_EVENT_REG_RESET 16'h0000
`define PHY_EVENT_FLAG_LSB 0
`define PHY_EVENT_EN_LSB 8
`define PHY_EVENT_NUM 8

`define EV_AUTONEG_DONE 0
`define EV_REMOTE_FLT 1
`define EV_LINK_FAIL 2
`define EV_PARTNER_ACK 3
`define EV_PAR_DETECT_FAULT 4
`define EV_PAGE_RCVD 5
`define EV_RX_ERROR 6
`define EV_JAB 7

`endif

/* hw/phy_event_pkg.sv */
package phy_event_pkg;
    // Raw event inputs, one-cycle pulses from the PHY detectors, except link_ok, which is a level.
    typedef struct packed {
        logic jab;
        logic rx_error;
        logic page_rcvd;
        logic par_detect_fault;
        logic partner_ack;
        logic link_ok;
        logic remote_flt;
        logic autoneg_done;
    } phy_events_s;

    // Management register access strobes.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
    } mgmt_req_s;
endpackage : phy_event_pkg

/* hw/phy_event_reg.sv */
`timescale 1ns/10ps
`include "phy_event_cfg.svh"
// Overview of operation
// [RQ1] The low byte holds eight event flags, each latching on its event.
// [RQ2] A management read of the register clears all eight flags.
// [RQ3] The high byte holds eight writable enables gating flags to the irq.
// [RQ4] The register sits at management address 0x11 for polling.
// [RQ5] Reset clears every enable and every flag, so the register reads 0.
// [RQ6] Bit 7 latches a jabber event and bit 15 enables it.
// [RQ7] Bit 6 latches a receive error and bit 14 enables it.
// [RQ8] Bit 5 latches a received page and bit 13 enables it.
// [RQ9] Bit 4 latches a parallel detection fault and bit 12 enables it.
// [RQ10] Bit 3 latches a partner acknowledge and bit 11 enables it.
// [RQ11] Bit 2 latches only a good-to-failed link change; bit 10 enables it.
// [RQ12] Bit 1 latches a remote fault and bit 9 enables it.
// [RQ13] Bit 0 latches auto-negotiation completion and bit 8 enables it.
// [RQ14] An event in the clearing read survives; irq is OR of enabled flags.
module phy_event_reg #(
    parameter int NUM_EVENTS = `PHY_EVENT_NUM
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Event sources.
    input wire phy_event_pkg::phy_events_s events,
    // Management access.
    input wire phy_event_pkg::mgmt_req_s req,
    output logic [15:0] rdata,
    output logic rvalid,
    // Interrupt toward the MAC raw interrupt status.
    output logic phy_irq
);
    import phy_event_pkg::*;

    localparam int REG_W = 16;

    // One bit per event position; a clash would merge two events.
    localparam logic [7:0] EV_MAP =
        (8'h01 << `EV_JAB) |
        (8'h01 << `EV_RX_ERROR) |
        (8'h01 << `EV_PAGE_RCVD) |
        (8'h01 << `EV_PAR_DETECT_FAULT) |
        (8'h01 << `EV_PARTNER_ACK) |
        (8'h01 << `EV_LINK_FAIL) |
        (8'h01 << `EV_REMOTE_FLT) |
        (8'h01 << `EV_AUTONEG_DONE);

    // The field map is fixed, so any other size leaves bits without a home.
    initial begin
        if (NUM_EVENTS != `PHY_EVENT_NUM) begin
            $error("phy_event_reg supports exactly eight events");
        end
        if (`PHY_EVENT_EN_LSB + NUM_EVENTS > REG_W) begin
            $error("phy_event_reg enable field does not fit the register");
        end
        if (`PHY_EVENT_FLAG_LSB + NUM_EVENTS > `PHY_EVENT_EN_LSB) begin
            $error("phy_event_reg flag field overlaps the enable field");
        end
        if (EV_MAP != 8'hFF) begin
            $error("phy_event_reg event positions clash");
        end
    end

    function automatic logic hit(input logic [4:0] a);
        hit = (a == `PHY_EVENT_REG_ADDR); // RQ4
    endfunction : hit

    // Assembles the register image from its two fields.
    function automatic logic [15:0] reg_image(
        input logic [7:0] en,
        input logic [7:0] flag
    );
        reg_image = 16'h0000;
        reg_image[`PHY_EVENT_EN_LSB +: 8] = en;
        reg_image[`PHY_EVENT_FLAG_LSB +: 8] = flag;
    endfunction : reg_image

    logic [7:0] flag_q;
    logic [7:0] en_q;
    logic [7:0] en_d;
    logic link_ok_q;
    logic link_drop;
    logic [7:0] ev;
    logic [7:0] pend;
    logic irq_d;
    logic rd_hit;
    logic wr_hit;

    // Named views of the enable and flag fields.
    logic jab_en;
    logic rx_error_en;
    logic page_rcvd_en;
    logic par_detect_fault_en;
    logic partner_ack_en;
    logic link_fail_en;
    logic remote_flt_en;
    logic autoneg_done_en;
    logic jab_flag;
    logic rx_error_flag;
    logic page_rcvd_flag;
    logic par_detect_fault_flag;
    logic partner_ack_flag;
    logic link_fail_flag;
    logic remote_flt_flag;
    logic autoneg_done_flag;

    // Other addresses are ignored: no answer and no change.
    assign rd_hit = req.rd && hit(req.addr); // RQ4
    assign wr_hit = req.wr && hit(req.addr); // RQ4

    // Field views taken from the enable and flag registers.
    assign jab_en = en_q[`EV_JAB];
    assign rx_error_en = en_q[`EV_RX_ERROR];
    assign page_rcvd_en = en_q[`EV_PAGE_RCVD];
    assign par_detect_fault_en = en_q[`EV_PAR_DETECT_FAULT];
    assign partner_ack_en = en_q[`EV_PARTNER_ACK];
    assign link_fail_en = en_q[`EV_LINK_FAIL];
    assign remote_flt_en = en_q[`EV_REMOTE_FLT];
    assign autoneg_done_en = en_q[`EV_AUTONEG_DONE];
    assign jab_flag = flag_q[`EV_JAB];
    assign rx_error_flag = flag_q[`EV_RX_ERROR];
    assign page_rcvd_flag = flag_q[`EV_PAGE_RCVD];
    assign par_detect_fault_flag = flag_q[`EV_PAR_DETECT_FAULT];
    assign partner_ack_flag = flag_q[`EV_PARTNER_ACK];
    assign link_fail_flag = flag_q[`EV_LINK_FAIL];
    assign remote_flt_flag = flag_q[`EV_REMOTE_FLT];
    assign autoneg_done_flag = flag_q[`EV_AUTONEG_DONE];

    // Link failure is an edge: only a falling link-good level counts, and
    // the history resets low so a link that is down at reset never flags.
    always_ff @(posedge clk) begin
        if (rst) begin
            link_ok_q <= 1'b0;
        end else begin
            link_ok_q <= events.link_ok;
        end
    end

    assign link_drop = link_ok_q && !events.link_ok; // RQ11

    always_comb begin
        ev = 8'h00;
        ev[`EV_JAB] = events.jab; // RQ6
        ev[`EV_RX_ERROR] = events.rx_error; // RQ7
        ev[`EV_PAGE_RCVD] = events.page_rcvd; // RQ8
        ev[`EV_PAR_DETECT_FAULT] = events.par_detect_fault; // RQ9
        ev[`EV_PARTNER_ACK] = events.partner_ack; // RQ10
        ev[`EV_LINK_FAIL] = link_drop; // RQ11
        ev[`EV_REMOTE_FLT] = events.remote_flt; // RQ12
        ev[`EV_AUTONEG_DONE] = events.autoneg_done; // RQ13
    end

    // Each flag is its own set-wins register: an event in the cycle of the
    // clearing read survives, so no event is ever dropped.
    for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_flag
        always_ff @(posedge clk) begin
            if (rst) begin
                flag_q[i] <= 1'b0; // RQ5
            end else if (ev[i]) begin
                flag_q[i] <= 1'b1; // RQ1 RQ14
            end else if (rd_hit) begin
                flag_q[i] <= 1'b0; // RQ2
            end
        end
    end

    // Only the high byte is writable; writes to the flag byte are dropped.
    always_comb begin
        en_d = en_q;
        if (wr_hit) begin
            en_d = req.wdata[`PHY_EVENT_EN_LSB +: 8]; // RQ3
        end
    end

    // Enables hold until the next write.
    always_ff @(posedge clk) begin
        if (rst) begin
            en_q <= 8'h00; // RQ5
        end else begin
            en_q <= en_d; // RQ3
        end
    end

    // A flag reaches the interrupt only while its enable is set.
    assign pend[`EV_JAB] = jab_flag && jab_en; // RQ6
    assign pend[`EV_RX_ERROR] = rx_error_flag && rx_error_en; // RQ7
    assign pend[`EV_PAGE_RCVD] = page_rcvd_flag && page_rcvd_en; // RQ8
    assign pend[`EV_PAR_DETECT_FAULT] =
        par_detect_fault_flag && par_detect_fault_en; // RQ9
    assign pend[`EV_PARTNER_ACK] = partner_ack_flag && partner_ack_en; // RQ10
    assign pend[`EV_LINK_FAIL] = link_fail_flag && link_fail_en; // RQ11
    assign pend[`EV_REMOTE_FLT] = remote_flt_flag && remote_flt_en; // RQ12
    assign pend[`EV_AUTONEG_DONE] =
        autoneg_done_flag && autoneg_done_en; // RQ13

    assign irq_d = |pend; // RQ3 RQ14

    // Answer strobe stands one cycle after each read hit.
    always_ff @(posedge clk) begin
        if (rst) begin
            rvalid <= 1'b0;
        end else begin
            rvalid <= rd_hit; // RQ4
        end
    end

    // Read data shows the flags as they stood before the clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= `PHY_EVENT_REG_RESET; // RQ5
        end else if (rd_hit) begin
            rdata <= reg_image(en_q, flag_q); // RQ4
        end
    end

    // Registered one cycle after the flag state.
    always_ff @(posedge clk) begin
        if (rst) begin
            phy_irq <= 1'b0;
        end else begin
            phy_irq <= irq_d; // RQ3 RQ14
        end
    end
endmodule : phy_event_reg

/* testbench/mac_irq_model.sv */
`timescale 1ns/10ps
module mac_irq_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic phy_irq,
    output logic mac_raw_irq_status
);
    always_ff @(posedge clk) begin
        if (rst) begin
            mac_raw_irq_status <= 1'b0;
        end else begin
            mac_raw_irq_status <= phy_irq;
        end
    end
endmodule : mac_irq_model

/* testbench/phy_event_reg_asserts.sv */
`timescale 1ns/10ps
module phy_event_reg_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire phy_event_pkg::phy_events_s events,
    input wire phy_event_pkg::mgmt_req_s req,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic phy_irq
);
    logic rd;
    assign rd = req.rd && req.addr == 5'h11;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    read_ack_a: assert property (rvalid == $past(rd))
        else $error("ack");
    data_hold_a: assert property (!rvalid |-> $stable(rdata))
        else $error("hold");
    jab_latch_a: assert property (events.jab ##1 rd |=> rdata[7])
        else $error("jab");
    flag_clear_a: assert property (
        rd && !events.jab ##1 rd |=> !rdata[7]) else $error("clear");
    event_keep_a: assert property (
        rd && events.rx_error ##1 rd |=> rdata[6]) else $error("keep");
    link_up_a: assert property (
        rd && events.link_ok ##1 rd && events.link_ok |=> !rdata[2])
        else $error("link");
    irq_or_a: assert property (
        rvalid |-> phy_irq == |(rdata[15:8] & rdata[7:0]))
        else $error("irq");
    en_off_a: assert property (
        req.wr && req.addr == 5'h11 && req.wdata[15:8] == 8'h00
        |=> ##1 !phy_irq) else $error("en");
endmodule : phy_event_reg_asserts
bind phy_event_reg phy_event_reg_asserts u_chk (.clk, .rst, .events, .req,
    .rdata, .rvalid, .phy_irq);

/* testbench/phy_event_reg_tb.sv */
`timescale 1ns/10ps
module phy_event_reg_tb;
    import phy_event_pkg::*;
    logic clk = 0;
    logic rst = 1;
    phy_events_s events = '0;
    mgmt_req_s req = '0;
    logic [15:0] rdata;
    logic rvalid, phy_irq, mac_irq;
    int failures = 0, num_checks = 0, cyc = 0;
    int en, fl, pl, rv, er, ei, ev, em;
    always #50 clk = ~clk;
    phy_event_reg u_dut (.clk, .rst, .events, .req, .rdata, .rvalid, .phy_irq);
    mac_irq_model u_mac (.clk, .rst, .phy_irq, .mac_raw_irq_status(mac_irq));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        ev = events & 8'hFB | (pl & !events.link_ok) << 2;
        em = ei;
        ei = (en & fl) != 0;
        rv = req.rd && req.addr == 5'h11;
        if (rv) er = en << 8 | fl;
        fl = (rv ? 0 : fl) | ev;
        if (req.wr && req.addr == 5'h11) en = req.wdata[15:8];
        pl = events.link_ok;
        if (rst) {en, fl, pl, rv, er, ei, em} = '0;
        cyc++;
        if (cyc > 3000) begin
            failures++;
            complete_run();
        end
    end
    always @(negedge clk) begin
        check(rdata, er[15:0]);
        check(rvalid, rv[0]);
        check(phy_irq, ei[0]);
        check(mac_irq, em[0]);
    end
    task automatic drive_random(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 events = 8'($urandom & $urandom);
            req.rd = $urandom % 4 == 0;
            req.wr = $urandom % 8 == 0;
            req.addr = $urandom % 4 ? 5'h11 : 5'($urandom);
            req.wdata = 16'($urandom) & ($urandom % 4 ? 16'hFFFF : 16'h00FF);
        end
    endtask : drive_random
    initial begin
        void'($urandom(32'h61C5));
        repeat (6) @(posedge clk);
        #1 rst = 0;
        $display("reset test done");
        drive_random(2000);
        $display("random test done");
        rst = 1;
        events = '0;
        req = '0;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        drive_random(300);
        $display("mid-run reset test done");
        complete_run();
    end
endmodule : phy_event_reg_tb
